/* src/pldc_regs.v */
// interrupt latch, line state mirror, scratch byte and accessory switch bank
// assumes the ulpi register engine presents one-cycle rd/wr strobes in mclk_i,
// edge enables and mode flags come from logic on mclk_i, comparators are async
//
// What this block does
// RL1 - latch bit set on unmasked edge: disconnect, vbus, session valid/end, id ground
// RL2 - reading the latch returns its bits then clears them; no write path
// RL3 - disconnect latch bit captures events only in host mode
// RL4 - latch bits 7:5 read zero; all latch bits reset to zero
// RL5 - debug register mirrors live line state in bits 1:0; rest zero
// RL6 - scratch byte resets zero, write/set/clear at three addresses, no side effect
// RL7 - set address ors byte in, clear address clears ones, base replaces
// RL8 - switch control at 19h/1ah/1bh write/set/clear, resets zero
// RL9 - link programs uart route enables before selecting accessory mode
// RL10 - while uart receive route is off, link data line 1 held high
// RL11 - bit 2 routes data 0 onto dm; bit 3 routes dp to data 1
// RL12 - bit 1 grounds the id pin; bits 0 and 7 read zero
// RL13 - bit 4 closes dm to left audio pin switch
// RL14 - dp to right/mic pin switch closed when bit 5 or bit 6 set
// RL15 - uart data also reaches audio pins through enabled audio switches
// RL16 - single-ended receivers disabled while any audio switch bit set
// RL17 - software avoids uart routes while audio switches are on
// RL18 - interrupt enable at 1dh/1eh/1fh write/set/clear, resets zero
// RL19 - bit 0: id begins floating raises alt_int; bit 1: stops floating
// RL20 - software enables id pull-up before relying on floating interrupts
// RL21 - bit 5 or vendor enable: conversion done rising raises alt_int
// RL22 - interrupt enable bits 4:2 and 7:6 read zero
// RL23 - event unmasked when its direction is enabled in rise or fall enable
`include "pldc_defs.vh"

module pldc_regs (
  input  wire                     mclk_i,                        // 10 mhz register clock
  input  wire                     srst_i,                        // sync reset, active high
  input  wire [`PLDC_ADDR_W-1:0]  reg_addr_i,                    // register address
  input  wire [`PLDC_DATA_W-1:0]  reg_wdata_i,                   // write data
  input  wire                     reg_wr_i,                      // write strobe, one cycle
  input  wire                     reg_rd_i,                      // read strobe, one cycle
  output reg  [`PLDC_DATA_W-1:0]  reg_rdata_o,                   // read data
  output reg                      reg_rvalid_o,                  // read data valid, one cycle
  output reg                      reg_hit_o,                     // last read hit this bank
  input  wire [`PLDC_SRC_N-1:0]   otg_src_i,                     // async comparator levels
  input  wire [`PLDC_SRC_N-1:0]   rise_enable_i,                 // rising edge enables
  input  wire [`PLDC_SRC_N-1:0]   fall_enable_i,                 // falling edge enables
  input  wire                     host_mode_i,                   // transceiver in host mode
  input  wire [`PLDC_LS_W-1:0]    line_state_i,                  // async line state
  input  wire                     id_float_i,                    // async id floating level
  input  wire                     resistor_conversion_done_i,    // conversion done flag
  input  wire                     vendor_rid_irq_enable_i,       // vendor copy of irq enable
  input  wire                     accessory_mode_select_i,       // accessory mode selected
  input  wire                     link_data0_i,                  // uart tx from link
  input  wire                     dp_level_i,                    // async dp receiver level
  output reg                      alt_int_o,                     // alternate interrupt pulse
  output reg                      id_ground_drive_o,             // id to ground switch
  output reg                      dm_uart_o,                     // uart tx level toward dm
  output reg                      dm_uart_oe_o,                  // drive dm from uart
  output reg                      link_data1_o,                  // uart rx toward link
  output reg                      link_data1_oe_o,               // drive link data line 1
  output reg                      left_audio_switch_o,           // dm to left audio pin
  output reg                      right_or_mic_switch_o,         // dp to right/mic pin
  output reg                      se_receiver_disable_o,         // single-ended receivers off
  output reg                      uart_transmit_route_enable_o,  // stored tx route bit
  output reg                      uart_receive_route_enable_o    // stored rx route bit
);

  wire [`PLDC_SRC_N-1:0]  src_sync;
  wire [`PLDC_LS_W-1:0]   ls_sync;
  wire                    id_float_sync;
  wire                    dp_sync;
  wire [7:0]              scratch_byte;
  wire [7:0]              accessory_switch_control;
  wire [7:0]              accessory_irq_enable;
  wire                    settled;

  reg  [`PLDC_SRC_N-1:0]  src_prev;
  reg  [`PLDC_SRC_N-1:0]  otg_irq_event_latch;
  reg  [`PLDC_SRC_N-1:0]  next_latch;
  reg  [`PLDC_SRC_N-1:0]  src_event;
  reg                     id_float_prev;
  reg                     rid_done_prev;
  reg                     next_alt_int;
  reg  [`PLDC_DATA_W-1:0] next_rdata;
  reg                     next_hit;
  reg                     latch_read;
  reg  [1:0]              settle_cnt;

  reg                     scr_wr;
  reg                     scr_set;
  reg                     scr_clr;
  reg                     ck_wr;
  reg                     ck_set;
  reg                     ck_clr;
  reg                     ie_wr;
  reg                     ie_set;
  reg                     ie_clr;

  // comparator and pin levels crossing in
  pldc_sync2 #(
    .W (`PLDC_SRC_N)
  ) u_src_sync (
    .mclk_i (mclk_i),
    .srst_i (srst_i),
    .d_i    (otg_src_i),
    .q_o    (src_sync)
  );

  pldc_sync2 #(
    .W (`PLDC_LS_W + 2)
  ) u_pin_sync (
    .mclk_i (mclk_i),
    .srst_i (srst_i),
    .d_i    ({dp_level_i, id_float_i, line_state_i}),
    .q_o    ({dp_sync, id_float_sync, ls_sync})
  );

  // write decode
  always @* begin
    scr_wr = 1'b0;
    scr_set = 1'b0;
    scr_clr = 1'b0;
    ck_wr = 1'b0;
    ck_set = 1'b0;
    ck_clr = 1'b0;
    ie_wr = 1'b0;
    ie_set = 1'b0;
    ie_clr = 1'b0;
    if (reg_wr_i) begin
      if (reg_addr_i == `PLDC_A_SCR_WR) begin
        scr_wr = 1'b1; // RL6
      end else if (reg_addr_i == `PLDC_A_SCR_SET) begin
        scr_set = 1'b1; // RL6
      end else if (reg_addr_i == `PLDC_A_SCR_CLR) begin
        scr_clr = 1'b1; // RL6
      end else if (reg_addr_i == `PLDC_A_CK_WR) begin
        ck_wr = 1'b1; // RL8
      end else if (reg_addr_i == `PLDC_A_CK_SET) begin
        ck_set = 1'b1; // RL8
      end else if (reg_addr_i == `PLDC_A_CK_CLR) begin
        ck_clr = 1'b1; // RL8
      end else if (reg_addr_i == `PLDC_A_IE_WR) begin
        ie_wr = 1'b1; // RL18
      end else if (reg_addr_i == `PLDC_A_IE_SET) begin
        ie_set = 1'b1; // RL18
      end else if (reg_addr_i == `PLDC_A_IE_CLR) begin
        ie_clr = 1'b1; // RL18
      end
    end
  end

  // RL7
  pldc_srwc_reg #(
    .IMPL (`PLDC_SCR_MASK),
    .RST  (`PLDC_SCR_RST)
  ) u_scratch (
    .mclk_i  (mclk_i),
    .srst_i  (srst_i),
    .wr_i    (scr_wr),
    .set_i   (scr_set),
    .clr_i   (scr_clr),
    .wdata_i (reg_wdata_i),
    .value_o (scratch_byte)
  );

  // mask keeps power flag and bit 7 at zero
  pldc_srwc_reg #(
    .IMPL (`PLDC_CK_MASK),
    .RST  (`PLDC_CK_RST)
  ) u_switch_ctl (
    .mclk_i  (mclk_i),
    .srst_i  (srst_i),
    .wr_i    (ck_wr),
    .set_i   (ck_set),
    .clr_i   (ck_clr),
    .wdata_i (reg_wdata_i),
    .value_o (accessory_switch_control)
  );

  // mask keeps the unimplemented and reserved bits at zero
  pldc_srwc_reg #(
    .IMPL (`PLDC_IE_MASK),
    .RST  (`PLDC_IE_RST)
  ) u_irq_enable (
    .mclk_i  (mclk_i),
    .srst_i  (srst_i),
    .wr_i    (ie_wr),
    .set_i   (ie_set),
    .clr_i   (ie_clr),
    .wdata_i (reg_wdata_i),
    .value_o (accessory_irq_enable)
  );

  // edge detectors stay blind until the synchronisers and the previous-value
  // flops hold real levels, so a pin already high at reset is no fresh edge;
  // events in the first cycles after reset are dropped for it
  always @(posedge mclk_i) begin
    if (srst_i) begin
      settle_cnt <= `PLDC_SETTLE_RST;
    end else if (settle_cnt != `PLDC_SETTLE_DONE) begin
      settle_cnt <= settle_cnt + `PLDC_SETTLE_STEP;
    end
  end

  assign settled = (settle_cnt == `PLDC_SETTLE_DONE);

  // otg event detection, one lane per source
  genvar gi;
  generate
    for (gi = 0; gi < `PLDC_SRC_N; gi = gi + 1) begin : g_src
      always @* begin
        src_event[gi] = settled & ((src_sync[gi] & ~src_prev[gi] & rise_enable_i[gi]) |
                                   (~src_sync[gi] & src_prev[gi] & fall_enable_i[gi])); // RL23
      end
    end
  endgenerate

  always @* begin
    latch_read = reg_rd_i && (reg_addr_i == `PLDC_A_LATCH);
    next_latch = otg_irq_event_latch;
    if (latch_read) begin
      next_latch = `PLDC_LATCH_RST; // RL2
    end
    // a new event in the read cycle survives the clear
    next_latch = next_latch | src_event; // RL1
    if (!host_mode_i) begin
      next_latch[`PLDC_SRC_HOSTDISC] = 1'b0; // RL3
    end
  end

  always @(posedge mclk_i) begin
    if (srst_i) begin
      src_prev <= `PLDC_LATCH_RST;
      otg_irq_event_latch <= `PLDC_LATCH_RST; // RL4
    end else begin
      src_prev <= src_sync;
      otg_irq_event_latch <= next_latch;
    end
  end

  // accessory interrupt events toward the rxcmd alt_int
  always @* begin
    next_alt_int = 1'b0;
    if (accessory_irq_enable[`PLDC_IE_FLT_BEGIN] && id_float_sync && !id_float_prev) begin
      next_alt_int = 1'b1; // RL19
    end
    if (accessory_irq_enable[`PLDC_IE_FLT_END] && !id_float_sync && id_float_prev) begin
      next_alt_int = 1'b1; // RL19
    end
    if ((accessory_irq_enable[`PLDC_IE_RID] || vendor_rid_irq_enable_i) &&
        resistor_conversion_done_i && !rid_done_prev) begin
      next_alt_int = 1'b1; // RL21
    end
    if (!settled) begin
      next_alt_int = 1'b0;
    end
  end

  always @(posedge mclk_i) begin
    if (srst_i) begin
      id_float_prev <= 1'b0;
      rid_done_prev <= 1'b0;
      alt_int_o <= 1'b0;
    end else begin
      id_float_prev <= id_float_sync;
      rid_done_prev <= resistor_conversion_done_i;
      alt_int_o <= next_alt_int;
    end
  end

  // read decode; unmapped addresses answer zero with hit low
  always @* begin
    next_rdata = `PLDC_ZERO_BYTE;
    next_hit = 1'b1;
    if (reg_addr_i == `PLDC_A_LATCH) begin
      next_rdata = {`PLDC_LATCH_PAD, otg_irq_event_latch}; // RL2 RL4
    end else if (reg_addr_i == `PLDC_A_DEBUG) begin
      next_rdata = {`PLDC_LS_PAD, ls_sync}; // RL5
    end else if (reg_addr_i >= `PLDC_A_SCR_WR && reg_addr_i <= `PLDC_A_SCR_CLR) begin
      next_rdata = scratch_byte; // RL6
    end else if (reg_addr_i >= `PLDC_A_CK_WR && reg_addr_i <= `PLDC_A_CK_CLR) begin
      next_rdata = accessory_switch_control; // RL8 RL12
    end else if (reg_addr_i >= `PLDC_A_IE_WR && reg_addr_i <= `PLDC_A_IE_CLR) begin
      next_rdata = accessory_irq_enable; // RL18 RL22
    end else begin
      next_hit = 1'b0;
    end
  end

  always @(posedge mclk_i) begin
    if (srst_i) begin
      reg_rdata_o <= `PLDC_ZERO_BYTE;
      reg_rvalid_o <= 1'b0;
      reg_hit_o <= 1'b0;
    end else begin
      reg_rvalid_o <= reg_rd_i;
      if (reg_rd_i) begin
        reg_rdata_o <= next_rdata;
        reg_hit_o <= next_hit;
      end
    end
  end

  // switch and routing outputs; registered, so they lag the write by one cycle
  always @(posedge mclk_i) begin
    if (srst_i) begin
      id_ground_drive_o <= 1'b0;
      left_audio_switch_o <= 1'b0;
      right_or_mic_switch_o <= 1'b0;
      se_receiver_disable_o <= 1'b0;
      uart_transmit_route_enable_o <= 1'b0;
      uart_receive_route_enable_o <= 1'b0;
    end else begin
      id_ground_drive_o <= accessory_switch_control[`PLDC_CK_IDGND]; // RL12
      // uart levels on dm/dp pass these switches to the audio pins
      left_audio_switch_o <= accessory_switch_control[`PLDC_CK_SPKL]; // RL13 RL15
      right_or_mic_switch_o <= accessory_switch_control[`PLDC_CK_SPKR] |
                               accessory_switch_control[`PLDC_CK_MIC]; // RL14 RL15
      se_receiver_disable_o <= accessory_switch_control[`PLDC_CK_SPKL] |
                               accessory_switch_control[`PLDC_CK_SPKR] |
                               accessory_switch_control[`PLDC_CK_MIC]; // RL16
      uart_transmit_route_enable_o <= accessory_switch_control[`PLDC_CK_TXD];
      uart_receive_route_enable_o <= accessory_switch_control[`PLDC_CK_RXD];
    end
  end

  // uart data paths, active only in accessory mode; the link sets the route
  // bits before entering that mode, so no glitch reaches the pins
  always @(posedge mclk_i) begin
    if (srst_i) begin
      dm_uart_o <= 1'b0;
      dm_uart_oe_o <= 1'b0;
      link_data1_o <= 1'b0;
      link_data1_oe_o <= 1'b0;
    end else begin
      dm_uart_o <= link_data0_i; // RL11
      dm_uart_oe_o <= accessory_mode_select_i & accessory_switch_control[`PLDC_CK_TXD]; // RL11 RL9
      link_data1_oe_o <= accessory_mode_select_i;
      if (accessory_switch_control[`PLDC_CK_RXD]) begin
        link_data1_o <= dp_sync; // RL11
      end else begin
        link_data1_o <= 1'b1; // RL10
      end
    end
  end

endmodule

/* src/pldc_defs.vh */
// register map, field positions and reset values of the latch/debug/carkit bank
// assumes a 6-bit immediate register address and 8-bit register data
`ifndef PLDC_DEFS_VH
`define PLDC_DEFS_VH

`define PLDC_ADDR_W       6
`define PLDC_DATA_W       8
`define PLDC_ZERO_BYTE    8'h00

// register addresses
`define PLDC_A_LATCH      6'h14
`define PLDC_A_DEBUG      6'h15
`define PLDC_A_SCR_WR     6'h16
`define PLDC_A_SCR_SET    6'h17
`define PLDC_A_SCR_CLR    6'h18
`define PLDC_A_CK_WR      6'h19
`define PLDC_A_CK_SET     6'h1a
`define PLDC_A_CK_CLR     6'h1b
`define PLDC_A_IE_WR      6'h1d
`define PLDC_A_IE_SET     6'h1e
`define PLDC_A_IE_CLR     6'h1f

// interrupt latch sources
`define PLDC_SRC_N        5
`define PLDC_SRC_HOSTDISC 0
`define PLDC_LATCH_RST    5'h00
`define PLDC_LATCH_PAD    3'h0

// settle count after reset before edges are trusted
`define PLDC_SETTLE_RST   2'h0
`define PLDC_SETTLE_STEP  2'h1
`define PLDC_SETTLE_DONE  2'h3

// line state mirror
`define PLDC_LS_W         2
`define PLDC_LS_PAD       6'h00

// accessory switch control fields
`define PLDC_CK_IDGND     1
`define PLDC_CK_TXD       2
`define PLDC_CK_RXD       3
`define PLDC_CK_SPKL      4
`define PLDC_CK_SPKR      5
`define PLDC_CK_MIC       6
`define PLDC_CK_MASK      8'h7e
`define PLDC_CK_RST       8'h00

// accessory interrupt enable fields
`define PLDC_IE_FLT_BEGIN 0
`define PLDC_IE_FLT_END   1
`define PLDC_IE_RID       5
`define PLDC_IE_MASK      8'h23
`define PLDC_IE_RST       8'h00

// scratch byte
`define PLDC_SCR_MASK     8'hff
`define PLDC_SCR_RST      8'h00

`endif

/* src/pldc_sync2.v */
// two-stage synchroniser for levels arriving from outside the mclk_i domain
// assumes inputs are quasi-static relative to the clock (comparators, pins)
module pldc_sync2 #(
  parameter W = 1
) (
  input  wire         mclk_i,   // register clock
  input  wire         srst_i,   // sync reset, active high
  input  wire [W-1:0] d_i,      // asynchronous level
  output reg  [W-1:0] q_o       // synchronised level
);

  reg [W-1:0] meta;

  // meta feeds only the second stage
  always @(posedge mclk_i) begin
    if (srst_i) begin
      meta <= {W{1'b0}};
      q_o  <= {W{1'b0}};
    end else begin
      meta <= d_i;
      q_o  <= meta;
    end
  end

endmodule

/* src/pldc_srwc_reg.v */
// byte register with write, bit-set and bit-clear access
// assumes at most one of wr_i, set_i, clr_i is high in a cycle
module pldc_srwc_reg #(
  parameter [7:0] IMPL = 8'hff,
  parameter [7:0] RST  = 8'h00
) (
  input  wire       mclk_i,   // register clock
  input  wire       srst_i,   // sync reset, active high
  input  wire       wr_i,     // replace value
  input  wire       set_i,    // or in written ones
  input  wire       clr_i,    // clear written ones
  input  wire [7:0] wdata_i,  // written byte
  output reg  [7:0] value_o   // stored value
);

  reg [7:0] next_value;

  always @* begin
    next_value = value_o;
    if (wr_i) begin
      next_value = wdata_i;
    end else if (set_i) begin
      next_value = value_o | wdata_i;
    end else if (clr_i) begin
      next_value = value_o & ~wdata_i;
    end
    // unimplemented bits never store a one
    next_value = next_value & IMPL;
  end

  always @(posedge mclk_i) begin
    if (srst_i) begin
      value_o <= RST & IMPL;
    end else begin
      value_o <= next_value;
    end
  end

endmodule

/* src/placeholder_none.v */
// no logic lives in this file

/* tb/pldc_regs_asserts.sv */
// concurrent checks on the ports of the latch/debug/accessory register bank
// assumes read answers one edge after the strobe and registered switch outputs
`include "pldc_defs.vh"
module pldc_regs_asserts (
  input wire       mclk_i,                        // register clock
  input wire       srst_i,                        // sync reset
  input wire [5:0] reg_addr_i,                    // register address
  input wire       reg_rd_i,                      // read strobe
  input wire [7:0] reg_rdata_o,                   // read data
  input wire       reg_rvalid_o,                  // read answer
  input wire       resistor_conversion_done_i,    // conversion done
  input wire       vendor_rid_irq_enable_i,       // vendor enable copy
  input wire       accessory_mode_select_i,       // accessory mode
  input wire       link_data0_i,                  // uart tx level
  input wire       alt_int_o,                     // alternate interrupt
  input wire       dm_uart_o,                     // uart level to dm
  input wire       dm_uart_oe_o,                  // dm drive enable
  input wire       link_data1_o,                  // uart rx to link
  input wire       link_data1_oe_o,               // link data 1 enable
  input wire       left_audio_switch_o,           // left switch
  input wire       right_or_mic_switch_o,         // right/mic switch
  input wire       se_receiver_disable_o,         // receivers off
  input wire       uart_transmit_route_enable_o,  // tx route bit
  input wire       uart_receive_route_enable_o    // rx route bit
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (srst_i);
  sequence rd_of(logic [5:0] lo, logic [5:0] hi);
    reg_rvalid_o && ($past(reg_addr_i) >= lo) && ($past(reg_addr_i) <= hi);
  endsequence
  read_answer_a: assert property (reg_rd_i |=> reg_rvalid_o)
    else $error("read strobe got no answer");
  latch_pad_a: assert property (rd_of(6'h14, 6'h14) |-> reg_rdata_o[7:5] == 3'h0)
    else $error("latch upper bits not zero");
  debug_pad_a: assert property (rd_of(6'h15, 6'h15) |-> reg_rdata_o[7:2] == 6'h00)
    else $error("line state mirror upper bits not zero");
  ctrl_pad_a: assert property (rd_of(6'h19, 6'h1b) |-> !reg_rdata_o[0] && !reg_rdata_o[7])
    else $error("switch control bits 0 or 7 not zero");
  ie_pad_a: assert property (rd_of(6'h1d, 6'h1f) |-> (reg_rdata_o & 8'hdc) == 8'h00)
    else $error("irq enable unimplemented bits not zero");
  se_off_a: assert property (se_receiver_disable_o == (left_audio_switch_o || right_or_mic_switch_o))
    else $error("receiver disable does not follow audio switches");
  rx_idle_high_a: assert property (link_data1_oe_o && !uart_receive_route_enable_o |-> link_data1_o)
    else $error("link data 1 not high with rx route off");
  tx_oe_a: assert property (dm_uart_oe_o == (uart_transmit_route_enable_o && $past(accessory_mode_select_i)))
    else $error("dm drive enable wrong");
  tx_data_a: assert property (dm_uart_oe_o |-> dm_uart_o == $past(link_data0_i))
    else $error("dm level does not follow link data 0");
  rid_alt_a: assert property ($rose(resistor_conversion_done_i) && vendor_rid_irq_enable_i
    |-> ##[1:2] alt_int_o)
    else $error("conversion done raised no alt interrupt");
  cover property (rd_of(6'h14, 6'h14) ##0 reg_rdata_o != 8'h00);
  cover property (alt_int_o);
  cover property (dm_uart_oe_o && link_data1_oe_o);
  cover property (se_receiver_disable_o);
endmodule

bind pldc_regs pldc_regs_asserts u_chk (.mclk_i(mclk_i), .srst_i(srst_i), .reg_addr_i(reg_addr_i),
  .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .reg_rvalid_o(reg_rvalid_o),
  .resistor_conversion_done_i(resistor_conversion_done_i), .vendor_rid_irq_enable_i(vendor_rid_irq_enable_i),
  .accessory_mode_select_i(accessory_mode_select_i), .link_data0_i(link_data0_i), .alt_int_o(alt_int_o),
  .dm_uart_o(dm_uart_o), .dm_uart_oe_o(dm_uart_oe_o), .link_data1_o(link_data1_o),
  .link_data1_oe_o(link_data1_oe_o), .left_audio_switch_o(left_audio_switch_o),
  .right_or_mic_switch_o(right_or_mic_switch_o), .se_receiver_disable_o(se_receiver_disable_o),
  .uart_transmit_route_enable_o(uart_transmit_route_enable_o),
  .uart_receive_route_enable_o(uart_receive_route_enable_o));

/* tb/pldc_link_model.sv */
// link-side register master: single byte reads and writes on the strobe port
// assumes a read answer within four edges; address and data scrambled when idle
module pldc_link_model (
  input  wire logic       mclk_i,   // register clock
  input  wire logic [7:0] rdata_i,  // read data
  input  wire logic       rvalid_i, // read answer
  output logic      [5:0] addr_o,   // register address
  output logic      [7:0] wdata_o,  // write data
  output logic            wr_o,     // write strobe
  output logic            rd_o      // read strobe
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    addr_o = 6'h00;
    wdata_o = 8'h00;
    wr_o = 1'b0;
    rd_o = 1'b0;
  end
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    @(posedge mclk_i);
    addr_o <= a;
    wdata_o <= d;
    wr_o <= 1'b1;
    @(posedge mclk_i);
    wr_o <= 1'b0;
    addr_o <= ~a;
    wdata_o <= ~d;
  endtask
  task automatic rd(input logic [5:0] a, output logic [7:0] d);
    int n;
    n = 0;
    @(posedge mclk_i);
    addr_o <= a;
    rd_o <= 1'b1;
    @(posedge mclk_i);
    rd_o <= 1'b0;
    addr_o <= ~a;
    #1;
    while (rvalid_i !== 1'b1 && n < 4) begin
      @(posedge mclk_i);
      #1;
      n++;
    end
    d = (rvalid_i === 1'b1) ? rdata_i : 8'hxx;
  endtask
endmodule

/* tb/testbench.sv */
// self-checking bench for the latch/debug/accessory register bank
// assumes the link model drives the register port; bench drives pins and levels
`include "pldc_defs.vh"
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk_i, srst_i, host, id_f, done, ven, mode, d0, dp;
  logic [4:0] src, re, fe;
  logic [1:0] ls;
  logic [5:0] addr;
  logic [7:0] wdata, rdata, rv;
  logic wr, rd, rvalid, hit, alt, idg, dmo, dmoe, ld1, ld1oe, spl, spr, sed, txe, rxe;
  int mismatches, checks;
  pldc_link_model link (.mclk_i(mclk_i), .rdata_i(rdata), .rvalid_i(rvalid), .addr_o(addr),
    .wdata_o(wdata), .wr_o(wr), .rd_o(rd));
  pldc_regs dut (.mclk_i(mclk_i), .srst_i(srst_i), .reg_addr_i(addr), .reg_wdata_i(wdata),
    .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata), .reg_rvalid_o(rvalid), .reg_hit_o(hit),
    .otg_src_i(src), .rise_enable_i(re), .fall_enable_i(fe), .host_mode_i(host), .line_state_i(ls),
    .id_float_i(id_f), .resistor_conversion_done_i(done), .vendor_rid_irq_enable_i(ven),
    .accessory_mode_select_i(mode), .link_data0_i(d0), .dp_level_i(dp), .alt_int_o(alt),
    .id_ground_drive_o(idg), .dm_uart_o(dmo), .dm_uart_oe_o(dmoe), .link_data1_o(ld1),
    .link_data1_oe_o(ld1oe), .left_audio_switch_o(spl), .right_or_mic_switch_o(spr),
    .se_receiver_disable_o(sed), .uart_transmit_route_enable_o(txe), .uart_receive_route_enable_o(rxe));
  initial begin
    mclk_i = 1'b0;
    forever #50 mclk_i = ~mclk_i;
  end
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic rchk(input logic [5:0] a, input logic [7:0] exp);
    link.rd(a, rv);
    chk(rv, exp);
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk_i);
    #1;
  endtask
  task automatic watch(input logic [7:0] exp);
    logic [7:0] n;
    n = 8'h00;
    repeat (8) begin
      @(posedge mclk_i);
      #1;
      if (alt === 1'b1) n++;
    end
    chk(n, exp);
  endtask
  task automatic t_reset;
    rchk(6'h14, 8'h00);
    rchk(6'h16, 8'h00);
    rchk(6'h19, 8'h00);
    rchk(6'h1d, 8'h00);
    chk({7'h00, hit}, 8'h01);
    rchk(6'h1c, 8'h00);
    chk({7'h00, hit}, 8'h00);
    $display("test reset done");
  endtask
  task automatic t_scratch;
    link.wr(6'h16, 8'ha5);
    link.wr(6'h17, 8'h0a);
    rchk(6'h16, 8'haf);
    link.wr(6'h18, 8'h0f);
    rchk(6'h18, 8'ha0);
    link.wr(6'h14, 8'hff);
    link.wr(6'h15, 8'hff);
    rchk(6'h14, 8'h00);
    rchk(6'h17, 8'ha0);
    $display("test scratch done");
  endtask
  task automatic t_ctrl;
    link.wr(6'h19, 8'hf3);
    rchk(6'h19, 8'h72);
    chk({4'h0, idg, spl, spr, sed}, 8'h0f);
    link.wr(6'h1b, 8'h20);
    rchk(6'h1a, 8'h52);
    chk({6'h00, spr, sed}, 8'h03);
    link.wr(6'h1b, 8'h40);
    cyc(2);
    chk({6'h00, spr, spl}, 8'h01);
    link.wr(6'h1a, 8'h20);
    link.wr(6'h1b, 8'h12);
    cyc(2);
    chk({5'h00, spr, sed, idg}, 8'h06);
    link.wr(6'h19, 8'h00);
    cyc(2);
    chk({7'h00, sed}, 8'h00);
    $display("test ctrl done");
  endtask
  task automatic t_uart;
    link.wr(6'h1a, 8'h0c);
    @(posedge mclk_i) mode <= 1'b1;
    dp <= 1'b0;
    cyc(5);
    chk({5'h00, txe, rxe, dmoe}, 8'h07);
    for (int i = 0; i < 4; i++) begin
      @(posedge mclk_i) d0 <= i[0];
      dp <= ~i[0];
      cyc(5);
      chk({6'h00, dmo, ld1}, {6'h00, i[0], ~i[0]});
    end
    link.wr(6'h1b, 8'h08);
    cyc(2);
    chk({6'h00, ld1oe, ld1}, 8'h03);
    @(posedge mclk_i) mode <= 1'b0;
    link.wr(6'h19, 8'h00);
    cyc(2);
    chk({6'h00, dmoe, ld1oe}, 8'h00);
    $display("test uart done");
  endtask
  task automatic t_latch;
    @(posedge mclk_i) re <= 5'h1f;
    fe <= 5'h00;
    host <= 1'b1;
    src <= 5'h1f;
    cyc(5);
    rchk(6'h14, 8'h1f);
    rchk(6'h14, 8'h00);
    @(posedge mclk_i) src <= 5'h00;
    cyc(5);
    rchk(6'h14, 8'h00);
    @(posedge mclk_i) host <= 1'b0;
    fe <= 5'h0a;
    src <= 5'h1f;
    cyc(5);
    rchk(6'h14, 8'h1e);
    @(posedge mclk_i) re <= 5'h00;
    src <= 5'h00;
    cyc(5);
    rchk(6'h14, 8'h0a);
    $display("test latch done");
  endtask
  task automatic t_irq;
    link.wr(6'h1d, 8'hff);
    rchk(6'h1d, 8'h23);
    link.wr(6'h1f, 8'h22);
    rchk(6'h1e, 8'h01);
    @(posedge mclk_i) id_f <= 1'b1;
    watch(8'h01);
    @(posedge mclk_i) id_f <= 1'b0;
    watch(8'h00);
    link.wr(6'h1d, 8'h02);
    @(posedge mclk_i) id_f <= 1'b1;
    watch(8'h00);
    @(posedge mclk_i) id_f <= 1'b0;
    watch(8'h01);
    @(posedge mclk_i) done <= 1'b1;
    watch(8'h00);
    @(posedge mclk_i) done <= 1'b0;
    ven <= 1'b1;
    cyc(2);
    @(posedge mclk_i) done <= 1'b1;
    watch(8'h01);
    @(posedge mclk_i) done <= 1'b0;
    ven <= 1'b0;
    link.wr(6'h1e, 8'h20);
    @(posedge mclk_i) done <= 1'b1;
    watch(8'h01);
    @(posedge mclk_i) done <= 1'b0;
    $display("test irq done");
  endtask
  task automatic t_debug;
    for (int i = 0; i < 4; i++) begin
      @(posedge mclk_i) ls <= i[1:0];
      cyc(4);
      rchk(6'h15, {6'h00, i[1:0]});
    end
    $display("test debug done");
  endtask
  task automatic print_verdict;
    $display("checks=%0d mismatches=%0d", checks, mismatches);
    if (mismatches == 0 && checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    mismatches = 0;
    checks = 0;
    srst_i = 1'b1;
    {host, id_f, done, ven, mode, d0, dp} = 7'h00;
    {src, re, fe} = 15'h0000;
    ls = 2'h0;
    repeat (20) @(posedge mclk_i);
    srst_i <= 1'b0;
    t_reset;
    t_scratch;
    t_ctrl;
    t_uart;
    t_latch;
    t_irq;
    t_debug;
    print_verdict;
  end
  initial begin
    #2000000;
    mismatches++;
    print_verdict;
  end
endmodule
